// File: logic/spm_link_shifter.sv
// byte shifter and serial clock generator on the link clock
`timescale 1ns/10ps
module spm_link_shifter (
    input  wire logic            link_clk_in,
    input  wire logic            link_rst_n_in,
    input  wire logic            req_tgl_in,
    input  wire spm_pkg::spm_cfg_t cfg_in,
    input  wire logic [7:0]      tx_byte_in,
    input  wire logic            miso_in,
    output logic                 sck_out,
    output logic                 mosi_out,
    output logic [7:0]           rx_byte_out,
    output logic                 done_tgl_out
);
    spm_pkg::spm_sh_state_t s;
    spm_pkg::spm_sh_state_t n;
    spm_pkg::spm_cfg_t      cfg_s;
    logic                   req_s;
    logic                   miso_s;
    logic                   start;

    spm_sync #(.W(12)) u_sync (
        .clk_in   (link_clk_in),
        .rst_n_in (link_rst_n_in),
        .d_in     ({req_tgl_in, cfg_in, miso_in}),
        .q_out    ({req_s, cfg_s, miso_s})
    );

    assign start = req_s ^ s.req_q;

    always_comb begin
        n = s;
        n.req_q = req_s;
        if (s.lag_act) begin
            if (s.lag == 2'h0) begin
                n.shreg   = {s.shreg[6:0], miso_s};
                n.lag_act = 1'b0;
            end else begin
                n.lag = s.lag - 2'h1;
            end
        end
        case (s.phase)
            spm_pkg::SH_IDLE: begin
                n.sck = cfg_s.cpol;
                if (start) begin
                    n.phase    = spm_pkg::SH_RUN;
                    n.cfg      = cfg_s;
                    n.shreg    = tx_byte_in;
                    n.mosi     = cfg_s.cpha ? s.mosi : tx_byte_in[7];
                    n.cnt      = spm_pkg::half_cycles(cfg_s.rate) - 9'h001;
                    n.edge_idx = 5'h00;
                    n.lag_act  = 1'b0;
                end
            end
            spm_pkg::SH_RUN: begin
                // no wait on the slave: the clock runs until all 16 edges are out
                if (s.cnt != 9'h000) begin
                    n.cnt = s.cnt - 9'h001;
                end else begin
                    n.cnt = spm_pkg::half_cycles(s.cfg.rate) - 9'h001;
                    if (s.edge_idx == spm_pkg::LAST_EDGE) begin
                        n.phase    = spm_pkg::SH_IDLE;
                        n.rx_hold  = n.shreg;
                        n.done_tgl = ~s.done_tgl;
                    end else begin
                        n.sck      = ~s.sck;
                        n.edge_idx = s.edge_idx + 5'h01;
                        if (s.edge_idx[0] == s.cfg.cpha) begin
                            n.lag_act = 1'b1;
                            n.lag     = spm_pkg::LAG_START;
                        end else begin
                            n.mosi = n.shreg[7];
                        end
                    end
                end
            end
            default: n = spm_pkg::SH_RST;
        endcase
    end

    always_ff @(posedge link_clk_in or negedge link_rst_n_in) begin
        if (!link_rst_n_in) begin
            s <= spm_pkg::SH_RST;
        end else begin
            s <= n;
        end
    end

    assign sck_out      = s.sck;
    assign mosi_out     = s.mosi;
    assign rx_byte_out  = s.rx_hold;
    assign done_tgl_out = s.done_tgl;

    default clocking @(posedge link_clk_in); endclocking
    default disable iff (!link_rst_n_in);

    property p_sck_lead_idle;
        s.phase == spm_pkg::SH_RUN && s.edge_idx == 5'h00 |-> s.sck == s.cfg.cpol;
    endproperty
    a_sck_lead_idle: assert property (p_sck_lead_idle) else $error("sck not idle before first edge");

    property p_first_bit;
        s.phase == spm_pkg::SH_IDLE && start && !cfg_s.cpha |=> s.mosi == $past(tx_byte_in[7]);
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("mosi not msb at start");

    property p_no_stall;
        s.phase == spm_pkg::SH_RUN && s.cnt != 9'h000 |=> s.cnt == $past(s.cnt) - 9'h001;
    endproperty
    a_no_stall: assert property (p_no_stall) else $error("shifter stalled");

    property p_end_idle;
        s.phase == spm_pkg::SH_RUN && s.edge_idx == spm_pkg::LAST_EDGE && s.cnt == 9'h000
            |=> s.phase == spm_pkg::SH_IDLE && s.sck == $past(s.cfg.cpol) && s.done_tgl != $past(s.done_tgl);
    endproperty
    a_end_idle: assert property (p_end_idle) else $error("byte did not close cleanly");
endmodule

// File: logic/spm_pkg.sv
// package: constants and types of the radio serial master
package spm_pkg;
    localparam int SYS_CLK_KHZ    = 50000;
    localparam int LINK_CLK_KHZ   = 12500;
    localparam int SCK_MAX_KHZ    = 12500;
    localparam int SAMPLE_LAG_CYC = 2;
    // half period in link cycles for each of the two bit-rate ceilings, rounded up
    localparam int SYS_HALF_CYC   = (LINK_CLK_KHZ + SYS_CLK_KHZ - 1) / SYS_CLK_KHZ;
    localparam int MAX_HALF_CYC   = (LINK_CLK_KHZ + 2 * SCK_MAX_KHZ - 1) / (2 * SCK_MAX_KHZ);
    localparam int LIM_HALF_CYC   = (SYS_HALF_CYC > MAX_HALF_CYC) ? SYS_HALF_CYC : MAX_HALF_CYC;
    // miso passes two flops, so a half period must outlast the sample lag
    localparam int MIN_HALF_CYC   = (LIM_HALF_CYC > SAMPLE_LAG_CYC) ? LIM_HALF_CYC : SAMPLE_LAG_CYC + 1;
    localparam logic [8:0] MIN_HALF       = 9'(MIN_HALF_CYC);
    localparam logic [1:0] LAG_START      = 2'(SAMPLE_LAG_CYC);
    localparam logic [4:0] LAST_EDGE      = 5'h10;
    localparam logic [1:0] SEL_MODE_MULTI = 2'h1;
    localparam int FLAG_DONE = 0;
    localparam int FLAG_WRITE_COLLISION_FLAG = 1;
    localparam int FLAG_MODE_FAULT_FLAG = 2;
    localparam int FLAG_OVR  = 3;

    typedef struct packed {
        logic       cpha;
        logic       cpol;
        logic [7:0] rate;
    } spm_cfg_t;

    typedef enum logic [0:0] {
        SH_IDLE = 1'b0,
        SH_RUN  = 1'b1
    } spm_phase_t;

    typedef struct packed {
        spm_phase_t phase;
        spm_cfg_t   cfg;
        logic [7:0] shreg;
        logic       mosi;
        logic       sck;
        logic [8:0] cnt;
        logic [4:0] edge_idx;
        logic       lag_act;
        logic [1:0] lag;
        logic [7:0] rx_hold;
        logic       done_tgl;
        logic       req_q;
    } spm_sh_state_t;

    typedef struct packed {
        logic [3:0] flags;
        logic       master_en;
        logic       iface_en;
        logic [1:0] sel_mode;
        spm_cfg_t   cfg;
        logic [7:0] tx_byte;
        logic       tx_empty;
        logic [7:0] xfer_byte;
        logic       busy;
        logic       req_tgl;
        logic       done_q;
        logic [7:0] rx_byte;
        logic       rx_full;
        logic       irq;
        logic       dma_tx;
        logic       dma_rx;
    } spm_sys_state_t;

    localparam spm_sys_state_t SYS_RST = '{tx_empty: 1'b1, default: '0};
    localparam spm_sh_state_t  SH_RST  = '{phase: SH_IDLE, default: '0};

    function automatic logic [8:0] half_cycles(input logic [7:0] rate);
        logic [8:0] h;
        h = {1'b0, rate} + 9'h001;
        return (h < MIN_HALF) ? MIN_HALF : h;
    endfunction
endpackage

// File: logic/spm_sync.sv
// two-flop level synchroniser
`timescale 1ns/10ps
module spm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= '0;
            q_out  <= '0;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule

// File: logic/spm_top.sv
// serial master towards the radio: flags, buffers, dma requests, link crossing
`timescale 1ns/10ps
module spm_top (
    // clocks and reset
    input  wire logic       CLOCK_IN,
    input  wire logic       RSTN_IN,
    input  wire logic       LINK_CLK_IN,
    // control and configuration
    input  wire logic       CTRL_WR_IN,
    input  wire logic       MASTER_EN_IN,
    input  wire logic       IFACE_EN_IN,
    input  wire logic [1:0] SEL_MODE_IN,
    input  wire logic       CLK_PHASE_IN,
    input  wire logic       CLK_POL_IN,
    input  wire logic [7:0] RATE_IN,
    input  wire logic       IRQ_EN_IN,
    input  wire logic [3:0] FLAG_CLR_IN,
    // data port, shared by processor and dma
    input  wire logic       DATA_WR_IN,
    input  wire logic [7:0] DATA_IN,
    input  wire logic       DATA_RD_IN,
    // status
    output logic [3:0]      FLAGS_OUT,
    output logic            MASTER_EN_OUT,
    output logic            IFACE_EN_OUT,
    output logic            SHIFT_BUSY_OUT,
    output logic            TX_BUFFER_EMPTY_OUT,
    output logic [7:0]      RX_DATA_OUT,
    output logic            IRQ_OUT,
    // dma requests
    output logic            DMA_TX_REQ_OUT,
    output logic            DMA_RX_REQ_OUT,
    // serial link
    input  wire logic       NSS_N_IN,
    input  wire logic       MISO_IN,
    output logic            SCK_OUT,
    output logic            MOSI_OUT
);
    spm_pkg::spm_sys_state_t s;
    spm_pkg::spm_sys_state_t n;
    logic                    rst_sys_n;
    logic                    rst_link_n;
    logic                    nss_s;
    logic                    done_s;
    logic                    done_tgl;
    logic [7:0]              rx_hold;
    logic                    done_evt;
    logic [3:0]              set;
    logic                    load;

    // reset released through two flops in each domain
    spm_sync #(.W(1)) u_rst_sys (
        .clk_in   (CLOCK_IN),
        .rst_n_in (RSTN_IN),
        .d_in     (1'b1),
        .q_out    (rst_sys_n)
    );

    spm_sync #(.W(1)) u_rst_link (
        .clk_in   (LINK_CLK_IN),
        .rst_n_in (RSTN_IN),
        .d_in     (1'b1),
        .q_out    (rst_link_n)
    );

    // select pin and the done toggle from the link domain
    spm_sync #(.W(2)) u_sync_in (
        .clk_in   (CLOCK_IN),
        .rst_n_in (rst_sys_n),
        .d_in     ({NSS_N_IN, done_tgl}),
        .q_out    ({nss_s, done_s})
    );

    // xfer_byte stays put from the request toggle until done returns
    spm_link_shifter u_shift (
        .link_clk_in   (LINK_CLK_IN),
        .link_rst_n_in (rst_link_n),
        .req_tgl_in    (s.req_tgl),
        .cfg_in        (s.cfg),
        .tx_byte_in    (s.xfer_byte),
        .miso_in       (MISO_IN),
        .sck_out       (SCK_OUT),
        .mosi_out      (MOSI_OUT),
        .rx_byte_out   (rx_hold),
        .done_tgl_out  (done_tgl)
    );

    assign done_evt = done_s ^ s.done_q;
    assign load     = !s.tx_empty && !s.busy && s.master_en && s.iface_en;

    always_comb begin
        set = 4'h0;
        set[spm_pkg::FLAG_DONE] = done_evt;
        set[spm_pkg::FLAG_WRITE_COLLISION_FLAG] = DATA_WR_IN && !s.tx_empty;
        set[spm_pkg::FLAG_MODE_FAULT_FLAG] = s.master_en && !nss_s
                                  && s.sel_mode == spm_pkg::SEL_MODE_MULTI;
        // only a slave keeps the old byte; this master-only block reaches it
        // when master mode was dropped under a running byte
        set[spm_pkg::FLAG_OVR]  = done_evt && s.rx_full && !s.master_en;
    end

    always_comb begin
        n = s;
        n.done_q = done_s;
        // a set in the clearing cycle survives
        n.flags = (s.flags & ~FLAG_CLR_IN) | set;
        if (CTRL_WR_IN) begin
            n.master_en = MASTER_EN_IN;
            n.iface_en  = IFACE_EN_IN;
            n.sel_mode  = SEL_MODE_IN;
            n.cfg.cpha  = CLK_PHASE_IN;
            n.cfg.cpol  = CLK_POL_IN;
            n.cfg.rate  = RATE_IN;
        end
        if (set[spm_pkg::FLAG_MODE_FAULT_FLAG]) begin
            n.master_en = 1'b0;
            n.iface_en  = 1'b0;
        end
        // same path for processor and dma writes
        if (DATA_WR_IN && s.tx_empty) begin
            n.tx_byte  = DATA_IN;
            n.tx_empty = 1'b0;
        end
        if (load) begin
            n.xfer_byte = s.tx_byte;
            n.tx_empty  = 1'b1;
            n.busy      = 1'b1;
            n.req_tgl   = ~s.req_tgl;
        end
        if (DATA_RD_IN) begin
            n.rx_full = 1'b0;
        end
        if (done_evt) begin
            n.busy = 1'b0;
            // unread bytes are overwritten in master mode, which drops miso data
            // when only the transmit channel runs
            if (!set[spm_pkg::FLAG_OVR]) begin
                n.rx_byte = rx_hold;
                n.rx_full = 1'b1;
            end
        end
        n.irq    = IRQ_EN_IN && (n.flags != 4'h0);
        // follows the buffer, not the shifter: the last write may still be shifting
        n.dma_tx = n.tx_empty && n.master_en && n.iface_en;
        n.dma_rx = n.rx_full;
    end

    always_ff @(posedge CLOCK_IN or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            s <= spm_pkg::SYS_RST;
        end else begin
            s <= n;
        end
    end

    assign FLAGS_OUT           = s.flags;
    assign MASTER_EN_OUT       = s.master_en;
    assign IFACE_EN_OUT        = s.iface_en;
    assign SHIFT_BUSY_OUT      = s.busy;
    assign TX_BUFFER_EMPTY_OUT = s.tx_empty;
    assign RX_DATA_OUT         = s.rx_byte;
    assign IRQ_OUT             = s.irq;
    assign DMA_TX_REQ_OUT      = s.dma_tx;
    assign DMA_RX_REQ_OUT      = s.dma_rx;

    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (!rst_sys_n);

    sequence s_accept_idle;
        DATA_WR_IN && s.tx_empty && !s.busy && s.master_en && s.iface_en
            && !CTRL_WR_IN && !set[spm_pkg::FLAG_MODE_FAULT_FLAG];
    endsequence

    sequence s_hand_to_shifter;
        !TX_BUFFER_EMPTY_OUT ##1 TX_BUFFER_EMPTY_OUT && SHIFT_BUSY_OUT;
    endsequence

    property p_done_flag;
        done_evt |=> FLAGS_OUT[spm_pkg::FLAG_DONE];
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag not set");

    property p_sticky;
        FLAGS_OUT[spm_pkg::FLAG_WRITE_COLLISION_FLAG] && !FLAG_CLR_IN[spm_pkg::FLAG_WRITE_COLLISION_FLAG]
            |=> FLAGS_OUT[spm_pkg::FLAG_WRITE_COLLISION_FLAG];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag cleared without software");

    property p_irq;
        IRQ_EN_IN && FLAGS_OUT[spm_pkg::FLAG_DONE] && !FLAG_CLR_IN[spm_pkg::FLAG_DONE] |=> IRQ_OUT;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_collision;
        DATA_WR_IN && !s.tx_empty
            |=> FLAGS_OUT[spm_pkg::FLAG_WRITE_COLLISION_FLAG] && s.tx_byte == $past(s.tx_byte);
    endproperty
    a_collision: assert property (p_collision) else $error("collision not handled");

    property p_mode_fault;
        s.master_en && !nss_s && s.sel_mode == spm_pkg::SEL_MODE_MULTI
            |=> FLAGS_OUT[spm_pkg::FLAG_MODE_FAULT_FLAG] && !MASTER_EN_OUT && !IFACE_EN_OUT;
    endproperty
    a_mode_fault: assert property (p_mode_fault) else $error("mode fault not handled");

    property p_overrun;
        done_evt && s.rx_full && !s.master_en && !DATA_RD_IN
            |=> FLAGS_OUT[spm_pkg::FLAG_OVR] && RX_DATA_OUT == $past(RX_DATA_OUT);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun lost old byte");

    property p_tx_empty_walk;
        s_accept_idle |=> s_hand_to_shifter;
    endproperty
    a_tx_empty_walk: assert property (p_tx_empty_walk) else $error("transmit empty sequence wrong");

    property p_busy_hold;
        SHIFT_BUSY_OUT && !done_evt |=> SHIFT_BUSY_OUT;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped mid transfer");

    property p_rx_req;
        done_evt && s.master_en |=> DMA_RX_REQ_OUT && RX_DATA_OUT == $past(rx_hold);
    endproperty
    a_rx_req: assert property (p_rx_req) else $error("receive request missing");

    property p_tx_req;
        s.tx_empty && s.master_en && s.iface_en && !DATA_WR_IN && !CTRL_WR_IN
            && !set[spm_pkg::FLAG_MODE_FAULT_FLAG] |=> DMA_TX_REQ_OUT;
    endproperty
    a_tx_req: assert property (p_tx_req) else $error("transmit request missing");

    property p_irq_gate;
        !IRQ_EN_IN |=> !IRQ_OUT;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");

    property p_load_toggle;
        load |=> SHIFT_BUSY_OUT && s.req_tgl != $past(s.req_tgl);
    endproperty
    a_load_toggle: assert property (p_load_toggle) else $error("byte not handed over");

    property p_wr_takes;
        DATA_WR_IN && s.tx_empty |=> s.tx_byte == $past(DATA_IN);
    endproperty
    a_wr_takes: assert property (p_wr_takes) else $error("write not taken");

    property p_wr_req_drop;
        DATA_WR_IN && s.tx_empty |=> !DMA_TX_REQ_OUT;
    endproperty
    a_wr_req_drop: assert property (p_wr_req_drop) else $error("transmit request stuck");

    property p_rd_clear;
        DATA_RD_IN && !done_evt |=> !DMA_RX_REQ_OUT;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("receive request stuck");

    property p_mode_fault_flag_sticky;
        FLAGS_OUT[spm_pkg::FLAG_MODE_FAULT_FLAG] && !FLAG_CLR_IN[spm_pkg::FLAG_MODE_FAULT_FLAG] |=> FLAGS_OUT[spm_pkg::FLAG_MODE_FAULT_FLAG];
    endproperty
    a_mode_fault_flag_sticky: assert property (p_mode_fault_flag_sticky) else $error("fault flag lost");

    property p_ovr_sticky;
        FLAGS_OUT[spm_pkg::FLAG_OVR] && !FLAG_CLR_IN[spm_pkg::FLAG_OVR] |=> FLAGS_OUT[spm_pkg::FLAG_OVR];
    endproperty
    a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun flag lost");

    property p_done_sticky;
        FLAGS_OUT[spm_pkg::FLAG_DONE] && !FLAG_CLR_IN[spm_pkg::FLAG_DONE] |=> FLAGS_OUT[spm_pkg::FLAG_DONE];
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

    property p_clear;
        FLAG_CLR_IN[spm_pkg::FLAG_DONE] && !done_evt |=> !FLAGS_OUT[spm_pkg::FLAG_DONE];
    endproperty
    a_clear: assert property (p_clear) else $error("done flag not cleared");

    property p_busy_end;
        done_evt |=> !SHIFT_BUSY_OUT;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy stuck after byte");

    property p_collide_full;
        DATA_WR_IN && !s.tx_empty && !load |=> !TX_BUFFER_EMPTY_OUT;
    endproperty
    a_collide_full: assert property (p_collide_full) else $error("buffer emptied by collision");

    property p_fault_off;
        !s.master_en && !CTRL_WR_IN |=> !MASTER_EN_OUT;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("master came back alone");

    property p_txe_load;
        load |=> TX_BUFFER_EMPTY_OUT;
    endproperty
    a_txe_load: assert property (p_txe_load) else $error("buffer not empty after load");

    property p_rx_keep;
        !done_evt |=> RX_DATA_OUT == $past(RX_DATA_OUT);
    endproperty
    a_rx_keep: assert property (p_rx_keep) else $error("receive byte changed");
endmodule

// File: testbench/spm_radio_model.sv
// behavioural radio slave: clock mode zero, msb first, one reply byte per byte
`timescale 1ns/10ps
module spm_radio_model (
    // serial link
    input  wire logic       sck_in,
    input  wire logic       mosi_in,
    input  wire logic       sel_n_in,
    output logic            miso_out,
    // bench side
    input  wire logic [7:0] resp_in,
    output logic [7:0]      got_out,
    output int              cnt_out
);
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [2:0] bit_i;
    logic       last;
    initial begin
        tx_sh = 8'h00;
        bit_i = 3'h0;
        last = 1'b0;
        cnt_out = 0;
        got_out = 8'h00;
    end
    // a released line shows the inverse of its last bit, so a stale sample never matches
    assign miso_out = sel_n_in ? ~last : tx_sh[7];
    always @(negedge sel_n_in) begin
        tx_sh = resp_in;
        bit_i = 3'h0;
    end
    always @(posedge sel_n_in) last = tx_sh[7];
    // no way to stall the master: every rising edge while selected is taken at whatever rate it comes
    always @(posedge sck_in) if (!sel_n_in) begin
        rx_sh = {rx_sh[6:0], mosi_in};
        bit_i = bit_i + 3'h1;
        if (bit_i == 3'h0) begin
            got_out = rx_sh;
            cnt_out++;
        end
    end
    always @(negedge sck_in) if (!sel_n_in) begin
        tx_sh = (bit_i == 3'h0) ? resp_in : {tx_sh[6:0], 1'b0};
    end
endmodule

// File: testbench/test_spi_master_dma_flags.sv
// self-checking bench of the radio serial master with a slave model on the link
`timescale 1ns/10ps
module test_spi_master_dma_flags;
    logic clk = 1'b0, rstn = 1'b0, link_clk = 1'b0, ctrl_wr = 1'b0, m_en = 1'b0, i_en = 1'b0;
    logic ph = 1'b0, pol = 1'b0, irq_en = 1'b0, dwr = 1'b0, drd = 1'b0, nss_n = 1'b1, rsel_n = 1'b1;
    logic [1:0] sel = 2'h0;
    logic [7:0] rate = 8'h02, din = 8'h00, resp = 8'h00;
    logic [3:0] fclr = 4'h0;
    logic [3:0] flags;
    logic       m_out, i_out, busy, txe, irq, dtx, drx, miso, sck, mosi;
    logic [7:0] rxd, got;
    int         rcnt, error_cnt = 0, tests_run = 0;
    real        sck_t = 0.0, min_half = 1.0e9;

    always #10 clk = ~clk;
    initial begin
        #13;
        forever #40 link_clk = ~link_clk;
    end
    always @(sck) begin
        if ($realtime - sck_t < min_half) min_half = $realtime - sck_t;
        sck_t = $realtime;
    end

    spm_top spm_top_i (
        .CLOCK_IN(clk), .RSTN_IN(rstn), .LINK_CLK_IN(link_clk), .CTRL_WR_IN(ctrl_wr),
        .MASTER_EN_IN(m_en), .IFACE_EN_IN(i_en), .SEL_MODE_IN(sel), .CLK_PHASE_IN(ph),
        .CLK_POL_IN(pol), .RATE_IN(rate), .IRQ_EN_IN(irq_en), .FLAG_CLR_IN(fclr),
        .DATA_WR_IN(dwr), .DATA_IN(din), .DATA_RD_IN(drd), .FLAGS_OUT(flags),
        .MASTER_EN_OUT(m_out), .IFACE_EN_OUT(i_out), .SHIFT_BUSY_OUT(busy),
        .TX_BUFFER_EMPTY_OUT(txe), .RX_DATA_OUT(rxd), .IRQ_OUT(irq), .DMA_TX_REQ_OUT(dtx),
        .DMA_RX_REQ_OUT(drx), .NSS_N_IN(nss_n), .MISO_IN(miso), .SCK_OUT(sck), .MOSI_OUT(mosi)
    );
    spm_radio_model spm_radio_model_i (
        .sck_in(sck), .mosi_in(mosi), .sel_n_in(rsel_n), .miso_out(miso),
        .resp_in(resp), .got_out(got), .cnt_out(rcnt)
    );

    task automatic close_out();
        $display("counts: %0d compared, %0d mismatched", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one cycle of waiting with a hard ceiling, so a hang ends the run
    task automatic tick(inout int n);
        cyc(1);
        n++;
        if (n > 3000) begin
            error_cnt++;
            $display("MISMATCH at %0t: wait ran out", $time);
            close_out();
        end
    endtask
    task automatic cfg(input logic [1:0] s, input logic p, input logic c, input logic [7:0] r);
        m_en = 1'b1;
        i_en = 1'b1;
        sel = s;
        ph = p;
        pol = c;
        rate = r;
        ctrl_wr = 1'b1;
        cyc(1);
        ctrl_wr = 1'b0;
        cyc(1);
    endtask
    task automatic send(input logic [7:0] b);
        int n;
        n = 0;
        while (txe !== 1'b1) tick(n);
        din = b;
        dwr = 1'b1;
        cyc(1);
        dwr = 1'b0;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        cyc(3);
        check(busy, 1'b1);
        // a queued byte leaves busy low for one cycle before it loads
        while (busy !== 1'b0 || txe !== 1'b1) tick(n);
    endtask
    task automatic clr(input logic [3:0] f);
        fclr = f;
        cyc(1);
        fclr = 4'h0;
        cyc(1);
    endtask
    task automatic rd();
        drd = 1'b1;
        cyc(1);
        drd = 1'b0;
        cyc(1);
    endtask

    task automatic t_reset();
        check(flags, 4'h0);
        check(txe, 1'b1);
        check({busy, irq, dtx, drx}, 4'h0);
        $display("test reset done");
    endtask
    task automatic t_byte();
        int c0;
        cfg(2'h0, 1'b0, 1'b0, 8'h02);
        irq_en = 1'b1;
        resp = 8'h3c;
        rsel_n = 1'b0;
        c0 = rcnt;
        send(8'ha5);
        check(txe, 1'b0);
        wait_idle();
        check(8'(rcnt - c0), 8'h01);
        check(got, 8'ha5);
        check(rxd, 8'h3c);
        check({flags, irq, drx}, 6'h07);
        rd();
        check(drx, 1'b0);
        cyc(30);
        check(flags, 4'h1);
        clr(4'h1);
        check({flags, irq}, 5'h00);
        $display("test byte done");
    endtask
    task automatic t_collide();
        int c0;
        c0 = rcnt;
        // the radio takes its next reply as the previous byte closes
        resp = 8'hc3;
        din = 8'h11;
        dwr = 1'b1;
        cyc(1);
        din = 8'h22;
        cyc(1);
        dwr = 1'b0;
        wait_idle();
        cyc(300);
        check({flags[1], irq, busy}, 3'h6);
        check(8'(rcnt - c0), 8'h01);
        check(got, 8'h11);
        rd();
        clr(4'hf);
        $display("test collision done");
    endtask
    task automatic t_stream();
        int c0, n;
        c0 = rcnt;
        n = 0;
        resp = 8'hc3;
        while (dtx !== 1'b1) tick(n);
        send({1'b1, 7'h12});
        send(8'h5a);
        while (drx !== 1'b1) tick(n);
        check(rxd, 8'hc3);
        rd();
        wait_idle();
        check(drx, 1'b1);
        check(rxd, 8'hc3);
        rd();
        check(8'(rcnt - c0), 8'h02);
        check(got, 8'h5a);
        clr(4'hf);
        $display("test stream done");
    endtask
    task automatic t_txonly();
        int c0;
        c0 = rcnt;
        send(8'h77);
        send(8'h88);
        check(busy, 1'b1);
        wait_idle();
        rsel_n = 1'b1;
        check(8'(rcnt - c0), 8'h02);
        check(got, 8'h88);
        check(flags[3], 1'b0);
        rd();
        clr(4'hf);
        $display("test transmit only done");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            cfg(2'h0, m[0], m[1], 8'h02);
            send(8'h0f);
            wait_idle();
            cyc(10);
            check(sck, m[1]);
            check(flags[0], 1'b1);
            clr(4'hf);
        end
        for (int r = 0; r < 8; r += 4) begin
            cfg(2'h0, 1'b0, 1'b0, 8'(r));
            min_half = 1.0e9;
            send(8'h3c);
            wait_idle();
            check(8'(int'(min_half / 80.0)), (r < 2) ? 8'h03 : 8'(r + 1));
        end
        clr(4'hf);
        $display("test clock modes done");
    endtask
    task automatic t_fault();
        logic [7:0] old;
        cfg(2'h0, 1'b0, 1'b0, 8'h02);
        nss_n = 1'b0;
        cyc(8);
        check({flags[2], m_out, i_out}, 3'h3);
        nss_n = 1'b1;
        cyc(3);
        cfg(2'h1, 1'b0, 1'b0, 8'h02);
        old = rxd;
        send(8'h55);
        cyc(3);
        nss_n = 1'b0;
        cyc(6);
        check({flags[2], m_out, i_out, irq, dtx}, 5'h12);
        nss_n = 1'b1;
        wait_idle();
        check({flags[3], flags[0]}, 2'h3);
        check(rxd, old);
        clr(4'hf);
        check(flags, 4'h0);
        $display("test mode fault done");
    endtask

    initial begin
        cyc(20);
        rstn = 1'b1;
        cyc(3);
        t_reset();
        t_byte();
        t_collide();
        t_stream();
        t_txonly();
        t_modes();
        t_fault();
        close_out();
    end
endmodule
